// >>> verilog/tad_pkg.sv
/*
  shared constants, state types and step-rate decoding for the transient
  acceleration event detector; assumes a 200 MHz system clock.
*/
package tad_pkg;
  localparam logic [7:0] ADDR_SRC = 8'h1E;
  localparam logic [7:0] ADDR_THS = 8'h1F;
  localparam logic [7:0] ADDR_CNT = 8'h20;
  localparam logic [7:0] SRC_RESET = 8'h00;
  localparam logic [7:0] THS_RESET = 8'h00;
  localparam logic [7:0] CNT_RESET = 8'h00;
  localparam int unsigned THS_MODE_BIT = 7;
  localparam int unsigned SRC_EA_BIT = 6;
  localparam int unsigned AXES = 3;
  // one threshold count is 63 mg, about 64 counts of 14-bit data at 8 g
  localparam int unsigned THS_SCALE_SHIFT = 6;
  localparam logic [1:0] FS_2G = 2'h0;
  localparam logic [1:0] FS_4G = 2'h1;
  localparam logic [1:0] FS_8G = 2'h2;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned STEP_BASE_NS = 1250000;
  localparam int unsigned STEP_BASE_CYCLES = STEP_BASE_NS / CLK_PERIOD_NS;
  localparam int unsigned BASE_W = 24;

  typedef enum logic [1:0] {
    TAD_OSR_NORMAL = 2'h0,
    TAD_OSR_LOW_POWER_LOW_NOISE_MODE = 2'h1,
    TAD_OSR_HIRES = 2'h2,
    TAD_OSR_LP = 2'h3
  } tad_osr_t;

  typedef struct packed {
    logic [AXES-1:0][7:0] dbc;
    logic [AXES-1:0] flag;
    logic [AXES-1:0] pol;
    logic ea;
    logic [7:0] ths;
    logic [7:0] cnt;
    logic [7:0] rdata;
  } tad_state_t;

  typedef struct packed {
    logic [BASE_W-1:0] base;
    logic [8:0] steps;
    logic tick;
  } tad_timer_t;

  // log2 of the step length in 1.25 ms units; odr code 0 is 800 Hz
  function automatic logic [3:0] tad_step_shift(input logic [2:0] odr, input tad_osr_t osr,
                                                 input logic hybrid);
    logic [3:0] s;
    s = (odr > 3'h4) ? 4'h4 : {1'b0, odr};
    unique case (osr)
      TAD_OSR_NORMAL: s = s;
      TAD_OSR_HIRES: s = (odr == 3'h0) ? 4'h0 : 4'h1;
      TAD_OSR_LOW_POWER_LOW_NOISE_MODE: s = (odr > 3'h4) ? 4'h6 : s;
      TAD_OSR_LP: s = (odr > 3'h5) ? 4'h7 : ((odr == 3'h5) ? 4'h6 : s);
    endcase
    return s + {3'h0, hybrid};
  endfunction
endpackage

// >>> verilog/tad_step_timer.sv
/*
  debounce step timer: one-cycle tick at each effective sample period.
  assumes odr, oversampling and hybrid settings are quasi-static.
*/
`timescale 1ns/1ps
module tad_step_timer #(
  parameter int unsigned BASE_CYCLES = tad_pkg::STEP_BASE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // rate selection
  input wire logic [2:0] odr_sel,
  input wire logic [1:0] osr_mode,
  input wire logic hybrid_mode,
  // step pulse
  output logic step_tick
);
  tad_pkg::tad_timer_t st_reg, st_next;
  logic [3:0] shift;
  logic [8:0] last_step;
  logic base_end;

  // trims the base period count to the counter width before comparing
  function automatic logic [tad_pkg::BASE_W-1:0] BASE_W_CAST(input int unsigned v);
    return v[tad_pkg::BASE_W-1:0];
  endfunction

  // step length from rate table; hybrid adds one doubling
  assign shift = tad_pkg::tad_step_shift(odr_sel, tad_pkg::tad_osr_t'(osr_mode), hybrid_mode);
  assign last_step = 9'((10'h001 << shift) - 10'h001);
  assign base_end = (st_reg.base == BASE_W_CAST(BASE_CYCLES - 1));

  // base count of 1.25 ms, then whole steps
  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    st_next.base = base_end ? '0 : st_reg.base + 1'b1;
    if (base_end) begin
      if (st_reg.steps >= last_step) begin
        st_next.steps = 9'h000;
        st_next.tick = 1'b1;
      end else begin
        st_next.steps = st_reg.steps + 9'h001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign step_tick = st_reg.tick;

  a_tick_spacing: assert property (@(posedge clk) disable iff (sys_rst)
    st_reg.tick |-> (st_reg.base == '0) && ($past(st_reg.base) == BASE_W_CAST(BASE_CYCLES - 1)))
    else $error("step tick not at end of base period");
endmodule // tad_step_timer

// >>> verilog/tad_detect.sv
/*
  transient acceleration event detector with its source, threshold and
  debounce count registers. assumes a simple byte register port driven by the
  serial interface logic, and 14-bit signed samples held between updates.
*/
`timescale 1ns/1ps
module tad_detect #(
  parameter int unsigned BASE_CYCLES = tad_pkg::STEP_BASE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rd_data,
  // acceleration samples, raw and high-pass filtered
  input wire logic [2:0][13:0] accel_raw,
  input wire logic [2:0][13:0] accel_hpf,
  // configuration from neighbouring registers
  input wire logic hpf_bypass,
  input wire logic [2:0] axis_enable,
  input wire logic latch_enable,
  input wire logic per_axis_ths_en,
  input wire logic [6:0] y_threshold,
  input wire logic [6:0] z_threshold,
  input wire logic low_noise,
  input wire logic [1:0] fs_range,
  input wire logic [2:0] odr_sel,
  input wire logic [1:0] osr_mode,
  input wire logic hybrid_mode,
  // event out
  output logic transient_event
);
  tad_pkg::tad_state_t st, st_next;
  logic step_tick;
  logic src_rd;
  logic freeze;
  logic [1:0] rng;
  logic [2:0] cond;
  logic [2:0] neg;
  logic [2:0] fire;
  logic [2:0][6:0] ths_ax;
  logic [2:0][13:0] sample;
  logic [2:0][14:0] mag;
  logic [2:0][14:0] mag8;

  tad_step_timer #(
    .BASE_CYCLES(BASE_CYCLES)
  ) u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .odr_sel(odr_sel),
    .osr_mode(osr_mode),
    .hybrid_mode(hybrid_mode),
    .step_tick(step_tick)
  );

  // magnitude of a signed 14-bit sample, widened so -8192 stays exact
  function automatic logic [14:0] abs14(input logic [13:0] v);
    return v[13] ? 15'(~{1'b1, v} + 15'h0001) : {1'b0, v};
  endfunction

  // low-noise forces the 4 g range whatever range is selected
  assign rng = low_noise ? tad_pkg::FS_4G : fs_range;
  assign src_rd = reg_rd_en && (reg_addr == tad_pkg::ADDR_SRC);
  // latched flags hold until a source read releases them
  assign freeze = latch_enable && st.ea && !src_rd;

  // per-axis data selection, scaling and threshold compare
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_axis
      assign sample[g] = hpf_bypass ? accel_raw[g] : accel_hpf[g];
      assign neg[g] = sample[g][13];
      assign mag[g] = abs14(sample[g]);
      // bring data to 8 g counts so the threshold scale never moves
      assign mag8[g] = (rng == tad_pkg::FS_2G) ? (mag[g] >> 2) :
                       ((rng == tad_pkg::FS_4G) ? (mag[g] >> 1) : mag[g]);
      assign cond[g] = axis_enable[g] &&
                       (mag8[g] > ({8'h00, ths_ax[g]} << tad_pkg::THS_SCALE_SHIFT));
    end
  endgenerate

  // thresholds: X from the register, Y and Z from outside when enabled
  always_comb begin
    ths_ax[0] = st.ths[6:0];
    ths_ax[1] = per_axis_ths_en ? y_threshold : st.ths[6:0];
    ths_ax[2] = per_axis_ths_en ? z_threshold : st.ths[6:0];
  end

  // register access, debounce and flag update in one next-state block
  always_comb begin
    st_next = st;
    fire = 3'h0;
    // register writes
    if (reg_wr_en && (reg_addr == tad_pkg::ADDR_THS)) begin
      st_next.ths = reg_wr_data;
    end
    if (reg_wr_en && (reg_addr == tad_pkg::ADDR_CNT)) begin
      st_next.cnt = reg_wr_data;
    end
    // reads capture the old value; unmapped offsets read zero
    if (reg_rd_en) begin
      unique case (reg_addr)
        tad_pkg::ADDR_SRC: st_next.rdata = {1'b0, st.ea, st.flag[2], st.pol[2],
                                            st.flag[1], st.pol[1], st.flag[0], st.pol[0]};
        tad_pkg::ADDR_THS: st_next.rdata = st.ths;
        tad_pkg::ADDR_CNT: st_next.rdata = st.cnt;
        default: st_next.rdata = 8'h00;
      endcase
    end
    // a source read clears flags and polarity
    if (src_rd) begin
      st_next.flag = 3'h0;
      st_next.pol = 3'h0;
    end
    // debounce only on step boundaries
    if (step_tick) begin
      for (int i = 0; i < 3; i++) begin
        if (cond[i]) begin
          st_next.dbc[i] = (st.dbc[i] == 8'hFF) ? 8'hFF : st.dbc[i] + 8'h01;
          // reaching the count register fires; a count of zero fires at once
          fire[i] = ({1'b0, st.dbc[i]} + 9'h001) >= {1'b0, st.cnt};
        end else if (!axis_enable[i] || st.ths[tad_pkg::THS_MODE_BIT]) begin
          st_next.dbc[i] = 8'h00;
        end else if (st.dbc[i] != 8'h00) begin
          st_next.dbc[i] = st.dbc[i] - 8'h01;
        end
        // a new event wins over a same-cycle read clear
        if (fire[i] && !freeze) begin
          st_next.flag[i] = 1'b1;
          st_next.pol[i] = neg[i];
        end
      end
    end
    st_next.ea = |st_next.flag;
  end

  // state register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= '0;
      st.ths <= tad_pkg::THS_RESET;
      st.cnt <= tad_pkg::CNT_RESET;
      st.rdata <= tad_pkg::SRC_RESET;
    end else begin
      st <= st_next;
    end
  end

  assign reg_rd_data = st.rdata;
  assign transient_event = st.ea;

  a_ea_summary: assert property (@(posedge clk) disable iff (sys_rst)
    st.ea == (st.flag != 3'h0))
    else $error("summary bit disagrees with axis flags");

  a_flag_cause: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(st.flag[0]) |-> $past(cond[0]) && $past(step_tick))
    else $error("x flag rose without over-threshold step");

  a_pol_sense: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(st.flag[1]) |-> st.pol[1] == $past(neg[1]))
    else $error("y polarity does not match sample sign");

  a_latch_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (latch_enable && st.ea && !src_rd) |=> $stable(st.flag) && $stable(st.pol))
    else $error("latched flags changed before read");

  a_read_clear: assert property (@(posedge clk) disable iff (sys_rst)
    (src_rd && !step_tick) |=> (st.flag == 3'h0) && !st.ea)
    else $error("source read did not clear flags");

  a_dec_mode: assert property (@(posedge clk) disable iff (sys_rst)
    (step_tick && axis_enable[0] && !cond[0] && !st.ths[7] && st.dbc[0] != 8'h00)
    |=> st.dbc[0] == 8'($past(st.dbc[0]) - 8'h01))
    else $error("debounce counter did not decrement");

  a_clear_mode: assert property (@(posedge clk) disable iff (sys_rst)
    (step_tick && !cond[2] && st.ths[7]) |=> st.dbc[2] == 8'h00)
    else $error("debounce counter not cleared");

  a_axis_off: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(st.flag[2]) |-> $past(axis_enable[2]))
    else $error("disabled z axis raised its flag");

  a_step_only: assert property (@(posedge clk) disable iff (sys_rst)
    !step_tick |=> $stable(st.dbc))
    else $error("debounce counters moved between steps");

  // per-axis repeats: a slip in one generate lane would hide behind the x checks
  a_cause_y: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(st.flag[1]) |-> $past(cond[1]) && $past(step_tick))
    else $error("y flag rose without over-threshold step");

  a_cause_z: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(st.flag[2]) |-> $past(cond[2]) && $past(step_tick))
    else $error("z flag rose without over-threshold step");

  a_pol_x: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(st.flag[0]) |-> st.pol[0] == $past(neg[0]))
    else $error("x polarity does not match sample sign");

  a_pol_z: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(st.flag[2]) |-> st.pol[2] == $past(neg[2]))
    else $error("z polarity does not match sample sign");

  a_pol_update: assert property (@(posedge clk) disable iff (sys_rst)
    (step_tick && fire[0] && !freeze) |=> st.flag[0] && (st.pol[0] == $past(neg[0])))
    else $error("later x event did not update flag and polarity");

  a_axis_off_x: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(st.flag[0]) |-> $past(axis_enable[0]))
    else $error("disabled x axis raised its flag");

  a_axis_off_y: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(st.flag[1]) |-> $past(axis_enable[1]))
    else $error("disabled y axis raised its flag");

  a_axis_dbc: assert property (@(posedge clk) disable iff (sys_rst)
    (step_tick && !axis_enable[1]) |=> st.dbc[1] == 8'h00)
    else $error("disabled y axis kept a debounce count");

  // threshold selection; the x and shared checks read the mux, the y and z own-threshold checks the pins
  a_ths_x_reg: assert property (@(posedge clk) disable iff (sys_rst)
    ths_ax[0] == st.ths[6:0])
    else $error("x threshold not taken from the register");

  a_ths_shared: assert property (@(posedge clk) disable iff (sys_rst)
    !per_axis_ths_en |-> (ths_ax[1] == st.ths[6:0]) && (ths_ax[2] == st.ths[6:0]))
    else $error("shared threshold not used for y and z");

  a_ths_y_own: assert property (@(posedge clk) disable iff (sys_rst)
    (per_axis_ths_en && axis_enable[1] && (mag8[1] > {2'b00, y_threshold, 6'h00})) |-> cond[1])
    else $error("y over its own threshold without condition");

  a_ths_z_own: assert property (@(posedge clk) disable iff (sys_rst)
    (per_axis_ths_en && axis_enable[2] && (mag8[2] > {2'b00, z_threshold, 6'h00})) |-> cond[2])
    else $error("z over its own threshold without condition");

  // range scaling keeps one threshold count the same acceleration
  a_scale_8g: assert property (@(posedge clk) disable iff (sys_rst)
    (rng == tad_pkg::FS_8G) |-> mag8[0] == mag[0])
    else $error("8 g data was rescaled");

  a_scale_4g: assert property (@(posedge clk) disable iff (sys_rst)
    (rng == tad_pkg::FS_4G) |-> mag8[1] == {1'b0, mag[1][14:1]})
    else $error("4 g data not halved");

  a_scale_2g: assert property (@(posedge clk) disable iff (sys_rst)
    (rng == tad_pkg::FS_2G) |-> mag8[2] == {2'b00, mag[2][14:2]})
    else $error("2 g data not quartered");

  a_low_noise: assert property (@(posedge clk) disable iff (sys_rst)
    low_noise |-> rng == tad_pkg::FS_4G)
    else $error("low-noise did not force the 4 g range");

  a_range_sel: assert property (@(posedge clk) disable iff (sys_rst)
    !low_noise |-> rng == fs_range)
    else $error("selected range not used");

  a_bypass_on: assert property (@(posedge clk) disable iff (sys_rst)
    hpf_bypass |-> sample[0] == accel_raw[0])
    else $error("bypass did not select raw data");

  a_bypass_off: assert property (@(posedge clk) disable iff (sys_rst)
    !hpf_bypass |-> sample[2] == accel_hpf[2])
    else $error("filtered data not selected");

  // debounce count and counter modes
  a_count_wait: assert property (@(posedge clk) disable iff (sys_rst)
    (step_tick && cond[0] && (({1'b0, st.dbc[0]} + 9'h001) < {1'b0, st.cnt})) |=> !$rose(st.flag[0]))
    else $error("x flag rose before the debounce count");

  a_count_one: assert property (@(posedge clk) disable iff (sys_rst)
    (step_tick && cond[0] && (st.cnt == 8'h01) && !freeze) |=> st.flag[0])
    else $error("count of one did not fire on the first step");

  a_wr_count: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_wr_en && (reg_addr == tad_pkg::ADDR_CNT)) |=> st.cnt == $past(reg_wr_data))
    else $error("count register write lost");

  a_wr_ths: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_wr_en && (reg_addr == tad_pkg::ADDR_THS)) |=> st.ths == $past(reg_wr_data))
    else $error("threshold register write lost");

  a_dec_floor: assert property (@(posedge clk) disable iff (sys_rst)
    (step_tick && axis_enable[1] && !cond[1] && !st.ths[7] && (st.dbc[1] == 8'h00)) |=> st.dbc[1] == 8'h00)
    else $error("debounce counter wrapped below zero");

  a_clear_x: assert property (@(posedge clk) disable iff (sys_rst)
    (step_tick && !cond[0] && st.ths[7]) |=> st.dbc[0] == 8'h00)
    else $error("x debounce counter not cleared");

  // source register behaviour seen by the host
  a_flag_sticky: assert property (@(posedge clk) disable iff (sys_rst)
    (st.flag[0] && !src_rd) |=> st.flag[0])
    else $error("x flag dropped without a source read");

  a_src_snap: assert property (@(posedge clk) disable iff (sys_rst)
    src_rd |=> !st.rdata[7] && (st.rdata[6] == $past(st.ea)) && (st.rdata[1] == $past(st.flag[0])))
    else $error("source read did not return the old flags");

  a_ea_out: assert property (@(posedge clk) disable iff (sys_rst)
    transient_event == (st.flag != 3'h0))
    else $error("event output disagrees with axis flags");

  a_tick_only: assert property (@(posedge clk) disable iff (sys_rst)
    !step_tick |=> !$rose(st.flag[1]))
    else $error("y flag rose between steps");
endmodule // tad_detect

// >>> tb/tad_host.sv
/*
  host model: byte reads and writes on the detector register port.
  assumes strobes are sampled on the rising clk edge.
*/
`timescale 1ns/1ps
module tad_host (
  // clock
  input wire logic clk,
  // register port
  output logic [7:0] reg_addr,
  output logic reg_wr_en,
  output logic [7:0] reg_wr_data,
  output logic reg_rd_en
);
  // idle off the map, so a stray strobe hits nothing
  initial begin
    reg_addr = 8'hFF;
    reg_wr_data = 8'h00;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
  end
  // one strobe cycle, then an idle cycle so read data never overlaps
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wr_data = wr ? d : ~d;
    reg_wr_en = wr;
    reg_rd_en = !wr;
    @(negedge clk);
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = ~a;
    reg_wr_data = ~d;
    @(negedge clk);
  endtask
endmodule // tad_host

// >>> tb/tb_top.sv
/*
  self-checking bench for the transient event detector.
  assumes tad_host drives the register port at falling edges.
*/
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data, v;
  logic reg_wr_en, reg_rd_en, transient_event;
  logic [2:0][13:0] raw = '0, hpf = '0;
  logic byp = 1'b1, lat = 1'b0, pax = 1'b0, lno = 1'b0, hyb = 1'b0, rd_d1 = 1'b0, rd_d2 = 1'b0;
  logic [2:0] axen = 3'h7, odr = 3'h0;
  logic [6:0] yth = 7'h7F, zth = 7'h7F;
  logic [1:0] fs = tad_pkg::FS_8G, osr = 2'h0;
  logic [7:0] exp_q[$];
  int err_total = 0, cmp_count = 0, cyc = 0, t0, m;
  int odr_t[7] = '{0, 1, 0, 2, 7, 5, 6};
  int osr_t[7] = '{0, 0, 0, 2, 0, 1, 3};
  int hyb_t[7] = '{0, 0, 1, 0, 0, 0, 0};
  int per_t[7] = '{4, 8, 8, 8, 64, 256, 512};
  always #2.5 clk = ~clk;
  tad_host i_tad_host (.clk(clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
    .reg_rd_en(reg_rd_en));
  // short step base keeps a debounce step four cycles long at odr code 0
  tad_detect #(.BASE_CYCLES(4)) i_tad_detect (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
    .accel_raw(raw), .accel_hpf(hpf), .hpf_bypass(byp), .axis_enable(axen), .latch_enable(lat),
    .per_axis_ths_en(pax), .y_threshold(yth), .z_threshold(zth), .low_noise(lno), .fs_range(fs),
    .odr_sel(odr), .osr_mode(osr), .hybrid_mode(hyb), .transient_event(transient_event));
  task automatic fail(input string s);
    $display("ERROR %0t %s", $time, s);
    err_total++;
  endtask
  task automatic test_done;
    if (exp_q.size() != 0) fail("reads left unchecked");
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk_ev(input logic e);
    cmp_count++;
    if (transient_event !== e) fail("event level");
  endtask
  task automatic chk_per(input int g, input int e);
    cmp_count++;
    if (g != e) fail("step period");
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_tad_host.xfer(1'b0, a, 8'h00);
  endtask
  // register accesses padded to one four-cycle step keep the tick phase
  task automatic rdt(input logic [7:0] a, input logic [7:0] e);
    rd(a, e);
    @(negedge clk);
  endtask
  task automatic wrt(input logic [7:0] a, input logic [7:0] d);
    i_tad_host.xfer(1'b1, a, d);
    @(negedge clk);
  endtask
  task automatic put(input int x, y, z, hx);
    raw = {14'(z), 14'(y), 14'(x)};
    hpf = {28'h0, 14'(hx)};
  endtask
  task automatic step(input int n);
    repeat (4 * n) @(negedge clk);
  endtask
  task automatic wait_ev;
    int n;
    n = 0;
    while (transient_event !== 1'b1 && n < 600) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 600) fail("no event");
  endtask
  // one step of the vector, then a quiet step while the source is read
  task automatic trial(input int x, y, z, hx, input logic [7:0] e);
    put(x, y, z, hx);
    step(1);
    put(0, 0, 0, 0);
    rdt(tad_pkg::ADDR_SRC, e);
  endtask
  // read pipeline, cycle count and hang limit
  always @(posedge clk) begin
    rd_d1 <= reg_rd_en;
    rd_d2 <= rd_d1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail("timeout");
      test_done();
    end
  end
  // oldest expected byte against the settled read data
  always @(negedge clk) begin
    if (rd_d2 === 1'b1) begin
      if (exp_q.size() == 0) fail("unexpected read");
      else begin
        cmp_count++;
        if (reg_rd_data !== exp_q.pop_front()) fail("read data");
      end
    end
  end
  initial begin
    v = 8'($urandom(32'h8414));
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    rd(tad_pkg::ADDR_SRC, tad_pkg::SRC_RESET);
    rd(tad_pkg::ADDR_THS, tad_pkg::THS_RESET);
    rd(tad_pkg::ADDR_CNT, tad_pkg::CNT_RESET);
    wrt(tad_pkg::ADDR_SRC, 8'hFF);
    rd(tad_pkg::ADDR_SRC, 8'h00);
    rd(8'h21, 8'h00);
    repeat (3) begin
      v = 8'($urandom);
      wrt(tad_pkg::ADDR_THS, v);
      rd(tad_pkg::ADDR_THS, v);
      wrt(tad_pkg::ADDR_CNT, ~v);
      rd(tad_pkg::ADDR_CNT, ~v);
    end
    $display("test registers done");
    wrt(tad_pkg::ADDR_THS, 8'h8A);
    wrt(tad_pkg::ADDR_CNT, 8'h01);
    put(700, 0, 0, 0);
    wait_ev;
    @(negedge clk);
    put(0, 0, 0, 0);
    rdt(tad_pkg::ADDR_SRC, 8'h42);
    for (int md = 0; md < 2; md++) begin
      wrt(tad_pkg::ADDR_THS, {md[0], 7'h0A});
      wrt(tad_pkg::ADDR_CNT, 8'h03);
      for (int i = 0; i < 6; i++) begin
        put(i == 2 ? 0 : 700, 0, 0, 0);
        step(1);
        chk_ev(i == 5 || (i == 4 && md == 0));
      end
      put(0, 0, 0, 0);
      rdt(tad_pkg::ADDR_SRC, 8'h42);
    end
    $display("test debounce done");
    wrt(tad_pkg::ADDR_CNT, 8'h01);
    lat = 1'b1;
    put(700, 0, 0, 0);
    step(1);
    chk_ev(1'b1);
    put(-700, -700, 0, 0);
    step(1);
    put(0, 0, 0, 0);
    rdt(tad_pkg::ADDR_SRC, 8'h42);
    lat = 1'b0;
    put(700, 0, 0, 0);
    step(1);
    put(-700, -700, 0, 0);
    step(1);
    put(0, 0, 0, 0);
    rdt(tad_pkg::ADDR_SRC, 8'h4F);
    rdt(tad_pkg::ADDR_SRC, 8'h00);
    chk_ev(1'b0);
    $display("test latching done");
    m = 700 + ($urandom % 7000);
    v[0] = 1'($urandom % 2);
    trial(v[0] ? -m : m, 0, 0, 0, {7'h21, v[0]});
    trial(640, 0, 0, 0, 8'h00);
    trial(-641, 0, 0, 0, 8'h43);
    axen = 3'h5;
    trial(0, 5000, 0, 0, 8'h00);
    axen = 3'h7;
    trial(400, 400, 400, 0, 8'h00);
    pax = 1'b1;
    yth = 7'h05;
    trial(400, 400, 400, 0, 8'h48);
    zth = 7'h05;
    trial(0, 0, 400, 0, 8'h60);
    pax = 1'b0;
    byp = 1'b0;
    trial(5000, 0, 0, 0, 8'h00);
    trial(0, 0, 0, 5000, 8'h42);
    byp = 1'b1;
    fs = tad_pkg::FS_2G;
    trial(2000, 0, 0, 0, 8'h00);
    lno = 1'b1;
    trial(2000, 0, 0, 0, 8'h42);
    lno = 1'b0;
    fs = tad_pkg::FS_8G;
    $display("test detection done");
    for (int i = 0; i < 7; i++) begin
      @(negedge clk);
      odr = 3'(odr_t[i]);
      osr = 2'(osr_t[i]);
      hyb = hyb_t[i][0];
      put(700, 0, 0, 0);
      wait_ev;
      @(negedge clk);
      rd(tad_pkg::ADDR_SRC, 8'h42);
      wait_ev;
      t0 = int'($time);
      @(negedge clk);
      rd(tad_pkg::ADDR_SRC, 8'h42);
      wait_ev;
      chk_per((int'($time) - t0) / 5, per_t[i]);
    end
    $display("test step periods done");
    test_done();
  end
endmodule // tb_top
